// [rtl/mcu_bus_interface.sv]
// host parallel bus interface: address capture, strobe mapping, data drive
//
// Contract
// (RL1) mux bus: capture address under latch strobe
// (RL2) latched address available on port A/B
// (RL3) drive addr/data port only on selected read
// (RL4) upper address bits come from general ports
// (RL5) non-mux: address on addr/data, data on A
// (RL6) non-mux: port A floats unless accessed
// (RL7) A0 picks even/odd byte; byte-high ignored
// (RL8) control inputs mapped per bus style
// (RL9) unused ctrl_in_2 serves as logic input
// (RL10) non-mux bus works without latch strobe
// (RL11) single read strobe on ctrl_in_1 only
// (RL12) two read strobes: either one reads
// (RL13) A16 may come in on port A pin 0
// (RL14) non-page: address latched every cycle
// (RL15) page hit: no strobe, low byte changes
// (RL16) page access timed from low address byte
// (RL17) burst host: A11-A4 muxed, A3-A0 separate
// (RL18) burst: upper held, A3-A0 stepped live
// (RL19) E-clock style: external read/write strobes
// (RL20) bus type from programmed configuration only
// (RL21) R/W select high reads, low writes
`include "mcu_bus_defs.svh"

module mcu_bus_interface (
   input wire logic clock,
   input wire logic srst,
   input wire logic [2:0] bus_type_cfg,
   input wire logic page_mode_cfg,
   input wire logic a16_on_porta_cfg,
   input wire logic portb_hi_cfg,
   input wire logic [7:0] addr_data_port_in,
   output logic [7:0] addr_data_port_out,
   output logic addr_data_port_oe,
   input wire logic [7:0] porta_in,
   output logic [7:0] porta_out,
   output logic porta_oe,
   input wire logic [7:0] addr_sep_in,
   input wire logic [3:0] addr_ext_in,
   input wire logic ctrl_in_0,
   input wire logic ctrl_in_1,
   input wire logic ctrl_in_2,
   input wire logic addr_latch_strobe,
   input wire logic byte_high_enable,
   input wire logic resource_hit,
   input wire logic [7:0] rd_data,
   output logic [19:0] bus_addr,
   output logic odd_byte,
   output logic rd_active,
   output logic wr_pulse,
   output logic [7:0] wr_data,
   output logic [7:0] latched_addr_a,
   output logic [7:0] latched_addr_b,
   output logic ctrl2_pld,
   output logic ext_rd,
   output logic ext_wr
);

   // multiplexed styles share address and data on the addr/data port
   function automatic logic is_muxed(input mcu_bus_pkg::bus_type_t t);
      is_muxed = (t != mcu_bus_pkg::bt_nonmux);
   endfunction

   mcu_bus_pkg::bus_type_t type_ff;
   mcu_bus_pkg::bus_type_t nxt_type;
   logic page_ff, nxt_page;
   logic a16_ff, nxt_a16;
   logic bhi_ff, nxt_bhi;

   // bus style is loaded only while reset is held [RL20]
   always_comb
   begin
      nxt_type = type_ff;
      nxt_page = page_ff;
      nxt_a16 = a16_ff;
      nxt_bhi = bhi_ff;
      if (srst)
      begin
         nxt_type = mcu_bus_pkg::bus_type_t'(bus_type_cfg); // [RL20]
         nxt_page = page_mode_cfg;
         nxt_a16 = a16_on_porta_cfg;
         nxt_bhi = portb_hi_cfg;
      end
   end

   always_ff @(posedge clock)
   begin
      type_ff <= nxt_type;
      page_ff <= nxt_page;
      a16_ff <= nxt_a16;
      bhi_ff <= nxt_bhi;
   end

   // strobe decode per style; pins sampled as synchronous levels
   logic rd_now, wr_now;
   always_comb
   begin
      rd_now = 1'b0;
      wr_now = 1'b0;
      unique case (type_ff)
         mcu_bus_pkg::bt_mux_rd_fetch, mcu_bus_pkg::bt_burst:
         begin
            wr_now = !ctrl_in_0; // [RL8]
            rd_now = !ctrl_in_1 || !ctrl_in_2; // [RL12]
         end
         mcu_bus_pkg::bt_mux_fetch_only, mcu_bus_pkg::bt_nonmux:
         begin
            wr_now = !ctrl_in_0;
            rd_now = !ctrl_in_1; // [RL11]
         end
         mcu_bus_pkg::bt_mux_rw_e:
         begin
            rd_now = ctrl_in_1 && ctrl_in_0; // [RL21]
            wr_now = ctrl_in_1 && !ctrl_in_0; // [RL21]
         end
         mcu_bus_pkg::bt_mux_rw_dstrobe:
         begin
            rd_now = !ctrl_in_1 && ctrl_in_0; // [RL8]
            wr_now = !ctrl_in_1 && !ctrl_in_0;
         end
         default:
         begin
            rd_now = 1'b0;
            wr_now = 1'b0;
         end
      endcase
   end

   // address capture: reloaded every clock while strobe high (mux styles only), held after it falls
   logic [7:0] alat_ff, nxt_alat;
   logic [7:0] hlat_ff, nxt_hlat;
   always_comb
   begin
      nxt_alat = alat_ff;
      nxt_hlat = hlat_ff;
      if (srst)
      begin
         nxt_alat = `DATA_RST;
         nxt_hlat = `DATA_RST;
      end
      else if (addr_latch_strobe && is_muxed(type_ff))
      begin
         nxt_alat = addr_data_port_in; // [RL1] [RL14]
         nxt_hlat = addr_sep_in; // [RL18]
      end
   end

   always_ff @(posedge clock)
   begin
      alat_ff <= nxt_alat;
      hlat_ff <= nxt_hlat;
   end

   // address assembly per style; the live parts give page/burst access
   logic [19:0] addr_now;
   always_comb
   begin
      addr_now = {addr_ext_in, addr_sep_in, alat_ff}; // [RL4] [RL14]
      unique case (type_ff)
         mcu_bus_pkg::bt_nonmux:
            addr_now = {addr_ext_in, addr_sep_in, addr_data_port_in}; // [RL5] [RL10]
         mcu_bus_pkg::bt_burst:
            addr_now = {hlat_ff, alat_ff, porta_in[3:0]}; // [RL17] [RL18]
         default:
            if (page_ff)
               addr_now = {addr_ext_in, alat_ff, addr_sep_in}; // [RL15] [RL16]
      endcase
      if (a16_ff && type_ff != mcu_bus_pkg::bt_burst)
         addr_now[`A16_BIT] = porta_in[0]; // [RL13]
   end

   // access side: address, byte lane, read level, write trailing edge
   logic [19:0] addr_ff, nxt_addr;
   logic odd_ff, nxt_odd;
   logic rd_ff, nxt_rd;
   logic wrq_ff, nxt_wrq;
   logic wrp_ff, nxt_wrp;
   logic [7:0] wdat_ff, nxt_wdat;
   always_comb
   begin
      nxt_addr = addr_now;
      nxt_odd = addr_now[0]; // [RL7]
      nxt_rd = rd_now && resource_hit;
      nxt_wrq = wr_now;
      nxt_wrp = wrq_ff && !wr_now; // [RL8]
      nxt_wdat = wdat_ff;
      if (wr_now)
         nxt_wdat = is_muxed(type_ff) ? addr_data_port_in : porta_in; // [RL5]
      if (srst)
      begin
         nxt_addr = `ADDR_RST;
         nxt_odd = 1'b0;
         nxt_rd = 1'b0;
         nxt_wrq = 1'b0;
         nxt_wrp = 1'b0;
         nxt_wdat = `DATA_RST;
      end
   end

   always_ff @(posedge clock)
   begin
      addr_ff <= nxt_addr;
      odd_ff <= nxt_odd;
      rd_ff <= nxt_rd;
      wrq_ff <= nxt_wrq;
      wrp_ff <= nxt_wrp;
      wdat_ff <= nxt_wdat;
   end

   // data drive: only the port that carries data, only on a hit read
   logic adoe_ff, nxt_adoe;
   logic paoe_ff, nxt_paoe;
   logic [7:0] dout_ff, nxt_dout;
   always_comb
   begin
      nxt_adoe = is_muxed(type_ff) && resource_hit && rd_now; // [RL3]
      nxt_paoe = !is_muxed(type_ff) && resource_hit && rd_now; // [RL6]
      nxt_dout = rd_data;
      if (srst)
      begin
         nxt_adoe = 1'b0;
         nxt_paoe = 1'b0;
         nxt_dout = `DATA_RST;
      end
   end

   always_ff @(posedge clock)
   begin
      adoe_ff <= nxt_adoe;
      paoe_ff <= nxt_paoe;
      dout_ff <= nxt_dout;
   end

   // latched address outputs, spare control input, external strobes
   logic [7:0] laa_ff, nxt_laa;
   logic [7:0] lab_ff, nxt_lab;
   logic c2_ff, nxt_c2;
   logic erd_ff, nxt_erd;
   logic ewr_ff, nxt_ewr;
   always_comb
   begin
      nxt_laa = addr_now[7:0]; // [RL2]
      nxt_lab = bhi_ff ? addr_now[15:8] : addr_now[7:0]; // [RL2]
      // styles that read a second fetch strobe own ctrl_in_2
      nxt_c2 = (type_ff == mcu_bus_pkg::bt_mux_rd_fetch ||
                type_ff == mcu_bus_pkg::bt_burst) ? 1'b0 : ctrl_in_2; // [RL9]
      // misses only, so outside parts never fight an internal read
      nxt_erd = type_ff == mcu_bus_pkg::bt_mux_rw_e && rd_now && !resource_hit; // [RL19]
      nxt_ewr = type_ff == mcu_bus_pkg::bt_mux_rw_e && wr_now && !resource_hit; // [RL19]
      if (srst)
      begin
         nxt_laa = `DATA_RST;
         nxt_lab = `DATA_RST;
         nxt_c2 = 1'b0;
         nxt_erd = 1'b0;
         nxt_ewr = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      laa_ff <= nxt_laa;
      lab_ff <= nxt_lab;
      c2_ff <= nxt_c2;
      erd_ff <= nxt_erd;
      ewr_ff <= nxt_ewr;
   end

   // byte_high_enable has no effect on an 8-bit bus
   logic byte_high_unused;
   assign byte_high_unused = byte_high_enable; // [RL7]

   assign addr_data_port_out = dout_ff;
   assign addr_data_port_oe = adoe_ff;
   assign porta_out = dout_ff;
   assign porta_oe = paoe_ff;
   assign bus_addr = addr_ff;
   assign odd_byte = odd_ff;
   assign rd_active = rd_ff;
   assign wr_pulse = wrp_ff;
   assign wr_data = wdat_ff;
   assign latched_addr_a = laa_ff;
   assign latched_addr_b = lab_ff;
   assign ctrl2_pld = c2_ff; // [RL9]
   assign ext_rd = erd_ff;
   assign ext_wr = ewr_ff;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   sequence wr_end_s;
      wr_now ##1 !wr_now;
   endsequence

   sequence strobe_low_s;
      !addr_latch_strobe ##1 !addr_latch_strobe;
   endsequence

   addr_data_drive_a: assert property (addr_data_port_oe |-> type_ff != mcu_bus_pkg::bt_nonmux
      && $past(resource_hit)) else $error("addr/data driven outside hit read"); // [RL3]
   porta_float_a: assert property (!resource_hit |=> !porta_oe)
      else $error("port A driven without access"); // [RL6]
   write_edge_a: assert property (wr_end_s |=> wr_pulse)
      else $error("write trailing edge missed"); // [RL8]
   addr_hold_a: assert property (strobe_low_s |-> $stable(alat_ff))
      else $error("latched address moved"); // [RL1]
   rw_read_a: assert property ((type_ff == mcu_bus_pkg::bt_mux_rw_e && ctrl_in_1 && ctrl_in_0
      && resource_hit) |=> rd_active) else $error("R/W read not seen"); // [RL21]
   nonmux_lane_a: assert property (type_ff == mcu_bus_pkg::bt_nonmux
      |=> odd_byte == $past(addr_data_port_in[0])) else $error("byte lane wrong"); // [RL7]
   burst_low_a: assert property (type_ff == mcu_bus_pkg::bt_burst
      |=> bus_addr[3:0] == $past(porta_in[3:0])) else $error("burst nibble wrong"); // [RL18]
   page_low_a: assert property ((page_ff && is_muxed(type_ff)
      && type_ff != mcu_bus_pkg::bt_burst) |=> bus_addr[7:0] == $past(addr_sep_in))
      else $error("page low byte wrong"); // [RL15]
   spare_ctrl_a: assert property (type_ff == mcu_bus_pkg::bt_mux_rw_e
      |=> ctrl2_pld == $past(ctrl_in_2)) else $error("spare input not passed"); // [RL9]
   ext_miss_a: assert property (ext_rd |-> !$past(resource_hit))
      else $error("external read on a hit"); // [RL19]
   cfg_fixed_a: assert property (!$past(srst) |-> $stable(type_ff))
      else $error("bus type changed at run time"); // [RL20]

endmodule // mcu_bus_interface

// [inc/mcu_bus_defs.svh]
// widths, field positions and reset values of the host bus interface
`ifndef MCU_BUS_DEFS_SVH
`define MCU_BUS_DEFS_SVH
`define ADDR_W 20
`define DATA_W 8
`define ADDR_RST 20'h00000
`define DATA_RST 8'h00
`define A16_BIT 16
`define BURST_LO_W 4
`endif

// [inc/mcu_bus_pkg.sv]
// types shared by the host bus interface
package mcu_bus_pkg;
   // host bus styles, fixed by programmed configuration
   typedef enum logic [2:0] {
      bt_mux_rd_fetch,
      bt_mux_fetch_only,
      bt_mux_rw_e,
      bt_mux_rw_dstrobe,
      bt_nonmux,
      bt_burst
   } bus_type_t;
endpackage

// [test/mcu_host_model.sv]
// host microcontroller model driving the bus pins of the interface
module mcu_host_model (
   input wire logic clock,
   output logic [7:0] ad,
   output logic [7:0] sep,
   output logic [3:0] ext,
   output logic [7:0] pa,
   output logic [2:0] ctl,
   output logic astb
);
   timeunit 1ns;
   timeprecision 100ps;
   // pins idle before the first reset
   initial
   begin
      {ad, sep, ext, pa, ctl, astb} = {8'h00, 8'h00, 4'h0, 8'h00, 3'h7, 1'b0};
   end
   // move on n edges; pins always change 1 ns after an edge
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // address phase; a mux bus is released after the strobe, not left at the old value
   task automatic addr_phase(input logic [19:0] a, input logic mux);
      {ext, sep, ad} = a;
      astb = mux;
      step(1);
      astb = 1'b0;
      if (mux)
         ad = ~ad;
      step(1);
   endtask
   // hold the control pins for n cycles
   task automatic cycle(input logic [2:0] c, input int n);
      ctl = c;
      step(n);
   endtask
   // write; data held one cycle past the strobe, then released while the
   // one-cycle write pulse still shows, so the caller can look at it
   task automatic write(input logic [7:0] d, input logic [2:0] act, input logic [2:0] idle,
      input logic on_pa);
      if (on_pa)
         pa = d;
      else
         ad = d;
      cycle(act, 2);
      cycle(idle, 1);
      {pa, ad} = on_pa ? {~d, ad} : {pa, ~d};
   endtask
endmodule // mcu_host_model

// [test/mcu_bus_interface_test.sv]
// self-checking bench of the host bus interface
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
         $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
      if ((g) !== (e)) \
         n_errors++; \
   end
module mcu_bus_interface_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [2:0] bus_type_cfg = 3'h0;
   logic page_mode_cfg = 1'b0;
   logic a16_on_porta_cfg = 1'b0;
   logic portb_hi_cfg = 1'b0;
   logic byte_high_enable = 1'b0;
   logic resource_hit = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] h_ad, h_pa, addr_sep_in, addr_data_port_out, porta_out, wr_data;
   logic [7:0] latched_addr_a, latched_addr_b;
   logic [3:0] addr_ext_in;
   logic [2:0] ctl;
   logic addr_latch_strobe, addr_data_port_oe, porta_oe, odd_byte, rd_active, wr_pulse;
   logic ctrl2_pld, ext_rd, ext_wr;
   logic [19:0] bus_addr;
   int n_errors = 0;
   int checks_done = 0;
   // shared pins resolved from both drivers
   wire logic [7:0] addr_data_port_in = addr_data_port_oe ? addr_data_port_out : h_ad;
   wire logic [7:0] porta_in = porta_oe ? porta_out : h_pa;
   mcu_bus_interface uut (.clock, .srst, .bus_type_cfg, .page_mode_cfg, .a16_on_porta_cfg,
      .portb_hi_cfg, .addr_data_port_in, .addr_data_port_out, .addr_data_port_oe, .porta_in,
      .porta_out, .porta_oe, .addr_sep_in, .addr_ext_in, .ctrl_in_0(ctl[0]),
      .ctrl_in_1(ctl[1]), .ctrl_in_2(ctl[2]), .addr_latch_strobe, .byte_high_enable,
      .resource_hit, .rd_data, .bus_addr, .odd_byte, .rd_active, .wr_pulse, .wr_data,
      .latched_addr_a, .latched_addr_b, .ctrl2_pld, .ext_rd, .ext_wr);
   mcu_host_model host (.clock, .ad(h_ad), .sep(addr_sep_in), .ext(addr_ext_in),
      .pa(h_pa), .ctl, .astb(addr_latch_strobe));
   // 100 MHz clock
   initial
   begin
      forever #5 clock = ~clock;
   end
   // config is only taken under reset, so each style gets its own reset
   task automatic do_reset(input logic [2:0] t, input logic [2:0] idle);
      bus_type_cfg = t;
      host.ctl = idle;
      resource_hit = 1'b1;
      srst = 1'b1;
      host.step(5);
      `CHK("oe in reset", 2'b00, {addr_data_port_oe, porta_oe})
      srst = 1'b0;
   endtask
   task automatic chk_write(input logic [7:0] d);
      `CHK("write", {1'b1, d}, {wr_pulse, wr_data})
      host.step(1);
      `CHK("pulse end", 1'b0, wr_pulse)
   endtask
   task automatic t_mux();
      {a16_on_porta_cfg, portb_hi_cfg, byte_high_enable, rd_data} = {3'b111, 8'hC3};
      do_reset(3'h0, 3'b111);
      host.pa = 8'h01;
      host.addr_phase(20'hA7C35, 1'b1);
      host.cycle(3'b101, 2);
      `CHK("bus_addr", 20'hB7C35, bus_addr)
      `CHK("odd_byte", 1'b1, odd_byte)
      `CHK("latched", 16'h357C, {latched_addr_a, latched_addr_b})
      `CHK("addr/data drive", 10'h386, {addr_data_port_oe, addr_data_port_out, ctrl2_pld})
      host.cycle(3'b011, 2);
      `CHK("fetch read", 2'b11, {addr_data_port_oe, rd_active})
      resource_hit = 1'b0;
      host.cycle(3'b101, 2);
      `CHK("miss drive", 1'b0, addr_data_port_oe)
      host.cycle(3'b111, 1);
      host.pa = 8'h00;
      host.addr_phase(20'h01240, 1'b1);
      `CHK("relatch", 21'h002480, {bus_addr, odd_byte})
      host.write(8'h96, 3'b110, 3'b111, 1'b0);
      chk_write(8'h96);
      {a16_on_porta_cfg, portb_hi_cfg} = 2'b00;
   endtask
   task automatic t_fetch();
      do_reset(3'h1, 3'b111);
      host.addr_phase(20'h00411, 1'b1);
      `CHK("latched low", 16'h1111, {latched_addr_a, latched_addr_b})
      host.cycle(3'b011, 2);
      `CHK("ctrl2 only", 2'b00, {addr_data_port_oe, ctrl2_pld})
      host.cycle(3'b101, 2);
      `CHK("ctrl1 read", 10'h387, {addr_data_port_oe, addr_data_port_out, ctrl2_pld})
      host.cycle(3'b111, 1);
   endtask
   task automatic t_rw();
      do_reset(3'h2, 3'b101);
      host.addr_phase(20'h00288, 1'b1);
      host.cycle(3'b111, 2);
      `CHK("rw read", 2'b11, {addr_data_port_oe, rd_active})
      host.cycle(3'b101, 1);
      host.write(8'h4B, 3'b110, 3'b101, 1'b0);
      chk_write(8'h4B);
      resource_hit = 1'b0;
      host.cycle(3'b111, 2);
      `CHK("ext read", 2'b10, {ext_rd, addr_data_port_oe})
      host.cycle(3'b101, 1);
      host.cycle(3'b110, 1);
      `CHK("ext write", 2'b10, {ext_wr, ext_rd})
      host.cycle(3'b101, 1);
   endtask
   task automatic t_page();
      page_mode_cfg = 1'b1;
      do_reset(3'h3, 3'b111);
      host.addr_phase(20'h1229D, 1'b1);
      host.cycle(3'b101, 2);
      `CHK("page addr", 21'h033A45, {bus_addr, addr_data_port_oe})
      host.sep = 8'h23;
      host.step(2);
      `CHK("page hit", 21'h033A47, {bus_addr, addr_data_port_oe})
      host.cycle(3'b111, 1);
      page_mode_cfg = 1'b0;
   endtask
   task automatic t_nonmux();
      do_reset(3'h4, 3'b111);
      host.addr_phase(20'h5E1F0, 1'b0);
      `CHK("port a idle", 1'b0, porta_oe)
      host.cycle(3'b101, 2);
      `CHK("nonmux read", 10'h386, {porta_oe, porta_out, addr_data_port_oe})
      `CHK("nonmux addr", 20'h5E1F0, bus_addr)
      host.cycle(3'b111, 2);
      `CHK("port a off", 1'b0, porta_oe)
      host.write(8'h3C, 3'b110, 3'b111, 1'b1);
      chk_write(8'h3C);
   endtask
   task automatic t_burst();
      do_reset(3'h5, 3'b111);
      host.addr_phase(20'h0ABCD, 1'b1);
      host.cycle(3'b101, 1);
      for (int i = 0; i < 16; i++)
      begin
         host.pa = 8'(i);
         host.step(2);
         `CHK("burst addr", {1'b1, 16'hABCD, 4'(i)}, {addr_data_port_oe, bus_addr})
      end
      host.cycle(3'b111, 1);
   endtask
   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial
   begin
      #50us;
      n_errors++;
      finish_test();
   end
   // main sequence, one style after another
   initial
   begin
      host.step(1);
      t_mux();
      t_fetch();
      t_rw();
      t_page();
      t_nonmux();
      t_burst();
      finish_test();
   end
endmodule // mcu_bus_interface_test
